// file: src/vmon2_ctrl.sv
// control logic of the second supply-voltage monitor channel
`timescale 1ns/100ps
`include "vmon2_map.svh"
// Contract
// [R1] Software picks the threshold level before enabling; four bits here, two in the small variant.
// [R2] Software waits the detector settle time after enabling before dependent steps.
// [R3] The filter samples on the low-speed oscillator divided by 2, 4, 8 or 16.
// [R4] Software waits 2n+3 oscillator cycles after filter enable and after output disable.
// [R5] Filter disable is active high: 0 filters, 1 bypasses.
// [R6] A detection causes a reset when the reset/interrupt select is 1.
// [R7] A detection raises an interrupt when the reset/interrupt select is 0.
// [R8] Interrupt mode has a two-bit timing select and a one-bit type select.
// [R9] Reset mode has a negation select that decides when reset releases.
// [R10] Software clears the detect flag before setting the interrupt/reset enable.
// [R11] Interrupt or reset is issued only while the interrupt/reset enable is 1.
// [R12] In the filtered variant software sets the compare output enable last.
// [R13] Unfiltered interrupt mode waits 2 us after output enable, clears flag, then enables.
// [R14] Unfiltered reset mode enables interrupt/reset before the detector, output after settling.
// [R15] Disable order: output off, wait, interrupt/reset off, filter off, detector off.
// [R16] Other bits change only after detector, interrupt/reset and output enables are clear.
// [R17] With compare output disabled no flag is set and no interrupt or reset is issued.
module vmon2_ctrl
    import vmon2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire vmon2_cfg_s cfg,
    input  wire logic       detect_flag_clr,
    input  wire logic       cmp_below_pin,
    input  wire logic       low_speed_osc_pin,
    output logic            detector_on,
    output logic [3:0]      level_out,
    output logic            detect_flag,
    output logic            monitor_level,
    output logic            irq_req,
    output logic            irq_level_type,
    output logic            reset_req
);
    logic       cmp_s1;
    logic       cmp_s2;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic       osc_tick;
    logic       filt_val;
    logic       mon_now;
    logic       mon_prev;
    logic       rise_ev;
    logic       fall_ev;
    logic       event_hit;
    logic       gate_on;
    logic       irq_ev;
    logic       rst_ev;
    logic [3:0] hold_cnt;
    vmon2_rst_e rst_state;
    vmon2_rst_e next_rst_state;

    // both async inputs pass two flops before use
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end
        else
        begin
            cmp_s1 <= cmp_below_pin;
            cmp_s2 <= cmp_s1;
            osc_s1 <= low_speed_osc_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    assign osc_tick = osc_s2 && !osc_s3;

    vmon2_filter u_filter (
        .clk               (clk),
        .resetn            (resetn),
        .osc_tick          (osc_tick),
        .filter_sample_div (cfg.filter_sample_div),
        .raw_in            (cmp_s2),
        .filt_out          (filt_val)
    );

    // bypass when the disable bit is 1; see [R5]
    assign mon_now   = cfg.filter_disable ? cmp_s2 : filt_val;
    assign gate_on   = cfg.detector_enable && cfg.compare_output_enable; // see [R17]
    assign rise_ev   = mon_now && !mon_prev;
    assign fall_ev   = !mon_now && mon_prev;
    // timing select: 0 drop below, 1 rise above, other both edges; see [R8]
    assign event_hit = gate_on && ((cfg.irq_timing_sel == 2'b00) ? rise_ev :
                                   (cfg.irq_timing_sel == 2'b01) ? fall_ev :
                                   (rise_ev || fall_ev));
    assign irq_ev    = event_hit && cfg.irq_reset_enable && !cfg.reset_or_irq_sel; // see [R7] [R11]
    assign rst_ev    = gate_on && rise_ev && cfg.irq_reset_enable
                       && cfg.reset_or_irq_sel; // see [R6] [R11]
    assign detector_on    = cfg.detector_enable;
    assign level_out      = cfg.threshold_level_sel; // see [R1]
    assign irq_level_type = cfg.irq_type_sel; // see [R8]

    // set wins over clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            mon_prev      <= 1'b0;
            detect_flag   <= 1'b0;
            monitor_level <= 1'b0;
            irq_req       <= 1'b0;
        end
        else
        begin
            mon_prev      <= mon_now;
            monitor_level <= gate_on && mon_now;
            detect_flag   <= event_hit || rst_ev || (detect_flag && !detect_flag_clr); // see [R17]
            irq_req       <= irq_ev; // see [R11]
        end
    end

    // negation select 0: release a fixed time after level recovers; 1: release on flag clear
    always_comb
    begin
        next_rst_state = rst_state;
        case (rst_state)
            VMON2_IDLE:
                if (rst_ev)
                    next_rst_state = VMON2_ASSERT;
            VMON2_ASSERT:
                if (cfg.reset_negation_sel ? (detect_flag_clr && !rst_ev) : !mon_now) // see [R9]
                    next_rst_state = cfg.reset_negation_sel ? VMON2_IDLE : VMON2_HOLD;
            VMON2_HOLD:
                if (mon_now)
                    next_rst_state = VMON2_ASSERT;
                else if (hold_cnt == 4'(`VMON2_RST_HOLD_CYC - 1))
                    next_rst_state = VMON2_IDLE;
            default:
                next_rst_state = VMON2_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rst_state <= VMON2_IDLE;
            hold_cnt  <= 4'h0;
            reset_req <= 1'b0;
        end
        else
        begin
            rst_state <= next_rst_state;
            hold_cnt  <= (rst_state == VMON2_HOLD) ? 4'(hold_cnt + 4'h1) : 4'h0;
            reset_req <= (next_rst_state != VMON2_IDLE); // see [R6]
        end
    end
endmodule : vmon2_ctrl

// file: src/vmon2_map.svh
// constants for the second voltage monitor control block
`ifndef VMON2_MAP_SVH
`define VMON2_MAP_SVH
`define VMON2_LVL_W            4
`define VMON2_DIV_W            2
`define VMON2_FILT_DIS_RST     1'b1
`define VMON2_IRQ_RST_SEL_RST  1'b0
`define VMON2_FILT_CNT_W       5
`define VMON2_FILT_SAMPLES     3'h3
`define VMON2_CLK_MHZ          50
`define VMON2_RST_HOLD_NS      100
`define VMON2_RST_HOLD_CYC     ((`VMON2_RST_HOLD_NS * `VMON2_CLK_MHZ + 999) / 1000)
`endif

// file: src/vmon2_pkg.sv
// types for the second voltage monitor control block
package vmon2_pkg;
    typedef struct packed {
        logic       detector_enable;
        logic       compare_output_enable;
        logic       irq_reset_enable;
        logic       reset_or_irq_sel;
        logic       reset_negation_sel;
        logic       filter_disable;
        logic [1:0] filter_sample_div;
        logic [3:0] threshold_level_sel;
        logic [1:0] irq_timing_sel;
        logic       irq_type_sel;
    } vmon2_cfg_s;

    typedef enum logic [1:0] {
        VMON2_IDLE   = 2'b00,
        VMON2_ASSERT = 2'b01,
        VMON2_HOLD   = 2'b10
    } vmon2_rst_e;
endpackage : vmon2_pkg

// file: src/vmon2_filter.sv
// sampling noise filter clocked by the divided low-speed oscillator tick
`timescale 1ns/100ps
module vmon2_filter
    import vmon2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       osc_tick,
    input  wire logic [1:0] filter_sample_div,
    input  wire logic       raw_in,
    output logic            filt_out
);
    logic [4:0] div_cnt;
    logic [4:0] div_last;
    logic       sample_en;
    logic [2:0] hist;
    logic       next_filt;
    logic [4:0] next_div;

    // n = 2,4,8,16 by the two-bit select; see [R3]
    assign div_last  = 5'((5'h02 << filter_sample_div) - 5'h01);
    assign sample_en = osc_tick && (div_cnt >= div_last);
    assign next_div  = sample_en ? 5'h00 : (osc_tick ? 5'(div_cnt + 5'h01) : div_cnt);
    // output changes only after three matching samples
    assign next_filt = (hist == 3'b111) ? 1'b1 : ((hist == 3'b000) ? 1'b0 : filt_out);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            div_cnt  <= 5'h00;
            hist     <= 3'h0;
            filt_out <= 1'b0;
        end
        else
        begin
            div_cnt  <= next_div;
            if (sample_en)
                hist <= {hist[1:0], raw_in};
            filt_out <= next_filt;
        end
    end
endmodule : vmon2_filter

// file: test/vmon2_monitor.sv
// assertion checker for the voltage monitor control block
`timescale 1ns/100ps
module vmon2_monitor
    import vmon2_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire vmon2_cfg_s cfg,
    input wire logic       detect_flag_clr,
    input wire logic [3:0] level_out,
    input wire logic       detect_flag,
    input wire logic       irq_req,
    input wire logic       irq_level_type,
    input wire logic       reset_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_level_follow: assert property (level_out == cfg.threshold_level_sel)
        else $error("level output wrong");
    a_irq_type: assert property (irq_level_type == cfg.irq_type_sel)
        else $error("irq type wrong");
    a_irq_gated: assert property (irq_req |-> $past(cfg.irq_reset_enable)
        && !$past(cfg.reset_or_irq_sel)) else $error("irq while gated");
    a_irq_pulse: assert property (irq_req |=> !irq_req)
        else $error("irq longer than a cycle");
    a_irq_flag: assert property (irq_req |-> detect_flag)
        else $error("irq without flag");
    a_reset_gated: assert property ($rose(reset_req) |-> $past(cfg.reset_or_irq_sel)
        && $past(cfg.irq_reset_enable)) else $error("reset while gated");
    a_flag_needs_cmp: assert property ($rose(detect_flag)
        |-> $past(cfg.compare_output_enable)) else $error("flag with output off");
    a_reset_hold: assert property (reset_req && cfg.reset_negation_sel
        && !detect_flag_clr && !$past(detect_flag_clr) |=> reset_req)
        else $error("reset released early");
endmodule : vmon2_monitor
bind vmon2_ctrl vmon2_monitor mon_u (.clk(clk), .resetn(resetn), .cfg(cfg),
    .detect_flag_clr(detect_flag_clr), .level_out(level_out), .detect_flag(detect_flag),
    .irq_req(irq_req), .irq_level_type(irq_level_type), .reset_req(reset_req));

// file: test/tb_top.sv
// self-checking bench for the voltage monitor control block
`timescale 1ns/100ps
module tb_top
    import vmon2_pkg::*;
;
    logic       clk = 0;
    logic       resetn = 0;
    vmon2_cfg_s cfg;
    logic       clr = 0;
    logic       pin = 0;
    logic       osc = 0;
    logic       det_on, flag, mon, irq, irq_t, rst;
    logic [3:0] lvl;
    int         bad_count = 0;
    int         total_checks = 0;
    int         irq_cnt = 0;
    vmon2_ctrl dut_u (.clk(clk), .resetn(resetn), .cfg(cfg), .detect_flag_clr(clr),
        .cmp_below_pin(pin), .low_speed_osc_pin(osc), .detector_on(det_on),
        .level_out(lvl), .detect_flag(flag), .monitor_level(mon), .irq_req(irq),
        .irq_level_type(irq_t), .reset_req(rst));
    initial forever #10 clk = ~clk;
    // oscillator kept fast so filter waits stay short
    initial forever #200 osc = ~osc;
    always @(posedge clk)
        if (irq === 1'b1)
            irq_cnt++;
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input int hi);
        irq_cnt = 0;
        @(negedge clk) pin = 1;
        repeat (hi) @(negedge clk);
        pin = 0;
        repeat (300) @(negedge clk);
    endtask : pulse
    task automatic clear_flag;
        @(negedge clk) clr = 1;
        @(negedge clk) clr = 0;
        repeat (3) @(negedge clk);
    endtask : clear_flag
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        #400000;
        bad_count++;
        final_report;
    end
    initial
    begin
        cfg = '0;
        cfg.filter_disable = 1'b1;
        repeat (10) @(negedge clk);
        resetn = 1;
        // pin idles low, so the settle wait is covered before the first pulse
        cfg = '{detector_enable:1, compare_output_enable:1, irq_reset_enable:1,
            filter_disable:1, threshold_level_sel:4'h9, irq_type_sel:1, default:0};
        @(negedge clk);
        chk(lvl, 4'h9);
        chk(irq_t, 1);
        chk(det_on, 1);
        for (int s = 0; s < 4; s++)
        begin
            cfg.irq_timing_sel = s[1:0];
            pulse(20);
            chk(irq_cnt[3:0], (s < 2) ? 4'h1 : 4'h2);
            chk(flag, 1);
            clear_flag;
            chk(flag, 0);
        end
        cfg.irq_timing_sel = 2'h0;
        cfg.irq_reset_enable = 0;
        pulse(20);
        chk(irq_cnt[3:0], 0);
        clear_flag;
        cfg.irq_reset_enable = 1;
        cfg.compare_output_enable = 0;
        pulse(20);
        chk(irq_cnt[3:0], 0);
        chk(flag, 0);
        chk(mon, 0);
        cfg.reset_or_irq_sel = 1;
        cfg.reset_negation_sel = 1;
        cfg.compare_output_enable = 1;
        pulse(20);
        chk(rst, 1);
        chk(irq_cnt[3:0], 0);
        clear_flag;
        chk(rst, 0);
        cfg.reset_negation_sel = 0;
        pulse(20);
        chk(rst, 0);
        clear_flag;
        cfg.reset_or_irq_sel = 0;
        cfg.filter_disable = 0;
        repeat (300) @(negedge clk);
        pulse(2);
        chk(flag, 0);
        pulse(200);
        chk(flag, 1);
        chk(irq_cnt[3:0], 1);
        clear_flag;
        // n = 16: one sample per 320 clocks, so a 200-clock pulse cannot pass
        cfg.filter_sample_div = 2'h3;
        repeat (700) @(negedge clk);
        pulse(200);
        chk(flag, 0);
        final_report;
    end
endmodule : tb_top
